/* File: design/dinit_ctrl.sv */
// DDR3 power-up initialization and mode-register programming controller
`timescale 1ns/1ns
`default_nettype none
`include "dinit_consts.svh"
// Functional notes
// R1: Hold device reset low until power is reported stable.
// R2: After power stable, keep reset low at least 200 us.
// R3: Device keeps termination off while reset low until CKE high.
// R4: Drive CKE low at least 10 ns before releasing reset.
// R5: Keep CKE low 500 us minus one clock after reset release.
// R6: Raise CKE on a clock edge; only NOP until MRS allowed.
// R7: Clock valid 10 ns and at least five cycles before CKE high.
// R8: Drive ODT low before CKE first registered high.
// R9: Keep CKE high on every edge until initialization completes.
// R10: First MRS after tXPR targets MR2 with BA 010.
// R11: Then MR3, MR1 with DLL on, MR0 with DLL reset.
// R12: Give 512 clocks for DLL lock after DLL reset.
// R13: Issue ZQCL after MR0; ready after tZQinit and DLL lock.
// R14: Device keeps mode values; DLL reset bit clears itself.
// R15: Each MRS carries the full register value.
// R16: Correct mode reprogramming leaves array contents intact.
// R17: MRS only when banks idle, precharged, no burst.
// R18: At least tMRD between consecutive MRS commands.
// R19: Only NOP for tMOD after MRS before other commands.
// R20: Settings unavailable until tMOD; DLL reset needs longer.
// R21: Hold ODT low from MRS edge until tMOD elapsed.
// R22: Hold CKE high from MRS until tMRSPDEN elapsed.
// R23: Time waits as rounded-up cycle counts in down-counters cnt, lock_cnt, mod_cnt and pden_cnt.
module dinit_ctrl
  import dinit_pkg::*;
#(
  parameter int RST_CYC  = (`DINIT_RST_US * 1000 + `DINIT_CLK_NS - 1) / `DINIT_CLK_NS, // R23
  parameter int CKE_CYC  = (`DINIT_CKE_LOW_US * 1000 + `DINIT_CLK_NS - 1) / `DINIT_CLK_NS - 1,
  parameter int CNT_W    = 16
) (
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  // Link clock from the memory clock generator
  input  wire logic        link_clk,
  // Power status pin
  input  wire logic        pwr_stable,
  // Init-time mode values
  input  wire dinit_addr_t mr0_val,
  input  wire dinit_addr_t mr1_val,
  input  wire dinit_addr_t mr2_val,
  input  wire dinit_addr_t mr3_val,
  // User MRS request
  input  wire logic        mrs_req,
  input  wire logic [2:0]  mrs_ba,
  input  wire dinit_addr_t mrs_val,
  input  wire logic        banks_idle,
  output logic             mrs_ack,
  output logic             init_done,
  output logic             mode_valid,
  output logic             pd_allowed,
  // DDR3 command pins
  output logic             mem_reset_n,
  output logic             mem_cke,
  output logic             mem_odt,
  output logic             mem_cs_n,
  output logic             mem_ras_n,
  output logic             mem_cas_n,
  output logic             mem_we_n,
  output logic [2:0]       mem_ba,
  output dinit_addr_t      mem_addr
);
  // ==========================================================
  // Reset release and input synchronisation
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  logic pwr_ok;
  dinit_sync #(.W(1)) u_pwr_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     (pwr_stable),
    .q     (pwr_ok)
  );

  // ==========================================================
  // Link clock activity: toggle in link domain, counted in core
  logic link_tog_q;
  logic link_rst_n;
  dinit_sync #(.W(1)) u_lrst_sync (
    .clk   (link_clk),
    .rst_n (arst_n),
    .d     (1'b1),
    .q     (link_rst_n)
  );
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      link_tog_q <= 1'b0;
    end else begin
      link_tog_q <= ~link_tog_q;
    end
  end
  logic link_tog_s;
  dinit_sync #(.W(1)) u_tog_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     (link_tog_q),
    .q     (link_tog_s)
  );

  // ==========================================================
  // State
  localparam int CLKV_CYC = (`DINIT_CLK_VALID_NS + `DINIT_CLK_NS - 1) / `DINIT_CLK_NS;
  localparam int CKER_CYC = (`DINIT_CKE_RST_NS + `DINIT_CLK_NS - 1) / `DINIT_CLK_NS;

  typedef struct packed {
    dinit_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [1:0]  mr_idx;
    logic [3:0]  edges;
    logic        tog;
    logic [9:0]  lock_cnt;
    logic [3:0]  mod_cnt;
    logic [3:0]  pden_cnt;
    logic        reset_n;
    logic        cke;
    logic        done;
    logic        ack;
    logic [2:0]  cmd;
    logic [2:0]  ba;
    dinit_addr_t addr;
  } dinit_reg_s;

  dinit_reg_s s_q, s_d;

  always_comb begin
    s_d      = s_q;
    s_d.ack  = 1'b0;
    s_d.cmd  = `DINIT_CMD_NOP; // R6
    s_d.tog  = link_tog_s;
    if (s_q.mod_cnt != 4'h0) begin
      s_d.mod_cnt = s_q.mod_cnt - 4'h1;
    end
    if (s_q.pden_cnt != 4'h0) begin
      s_d.pden_cnt = s_q.pden_cnt - 4'h1;
    end
    if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - CNT_W'(1);
    end
    case (s_q.st)
      DINIT_RST_HOLD: begin
        s_d.reset_n = 1'b0; // R1
        s_d.cke     = 1'b0; // R4
        if (!pwr_ok) begin
          s_d.cnt = CNT_W'(RST_CYC); // R2
        end else if (s_q.cnt == '0) begin
          s_d.reset_n = 1'b1; // R4
          s_d.cnt     = CNT_W'(CKE_CYC); // R5
          s_d.edges   = 4'h0;
          s_d.st      = DINIT_CKE_WAIT;
        end
      end
      DINIT_CKE_WAIT: begin
        if (s_q.tog != link_tog_s && s_q.edges != 4'hf) begin
          s_d.edges = s_q.edges + 4'h1;
        end
        if (s_q.cnt == '0) begin
          s_d.st = DINIT_CLK_WAIT;
        end
      end
      DINIT_CLK_WAIT: begin
        if (s_q.tog != link_tog_s && s_q.edges != 4'hf) begin
          s_d.edges = s_q.edges + 4'h1;
        end
        if (s_q.edges >= 4'(2 * `DINIT_CLK_VALID_MIN) && CLKV_CYC > 0) begin
          s_d.cke = 1'b1; // R7
          s_d.cnt = CNT_W'(`DINIT_TXPR_CYC);
          s_d.st  = DINIT_XPR;
        end
      end
      DINIT_XPR: begin
        if (s_q.cnt == '0) begin
          s_d.mr_idx = 2'h0;
          s_d.st     = DINIT_MRS;
        end
      end
      DINIT_MRS: begin
        s_d.cmd      = `DINIT_CMD_MRS; // R15
        s_d.mod_cnt  = 4'(`DINIT_TMOD_CYC); // R19
        s_d.pden_cnt = 4'(`DINIT_TMRSPDEN_CYC); // R22
        s_d.cnt      = CNT_W'(`DINIT_TMRD_CYC - 1); // R18
        s_d.st       = DINIT_MRS_GAP;
        case (s_q.mr_idx)
          2'h0: begin
            s_d.ba   = `DINIT_BA_MR2; // R10
            s_d.addr = mr2_val;
          end
          2'h1: begin
            s_d.ba   = `DINIT_BA_MR3; // R11
            s_d.addr = mr3_val;
          end
          2'h2: begin
            s_d.ba   = `DINIT_BA_MR1; // R11
            s_d.addr = mr1_val;
          end
          default: begin
            s_d.ba   = `DINIT_BA_MR0; // R11
            s_d.addr = mr0_val | (16'h1 << `DINIT_DLL_RST_BIT);
          end
        endcase
      end
      DINIT_MRS_GAP: begin
        if (s_q.cnt == '0) begin
          if (s_q.mr_idx != 2'h3) begin
            s_d.mr_idx = s_q.mr_idx + 2'h1;
            s_d.st     = DINIT_MRS;
          end else if (s_q.mod_cnt == 4'h0) begin
            s_d.st = DINIT_ZQ;
          end
        end
      end
      DINIT_ZQ: begin
        s_d.cmd      = `DINIT_CMD_ZQCL; // R13
        s_d.addr     = 16'h1 << `DINIT_ZQ_LONG_BIT;
        s_d.lock_cnt = 10'(`DINIT_TDLLK_CYC - `DINIT_TMOD_CYC); // R12
        s_d.cnt      = CNT_W'(`DINIT_TZQINIT_CYC);
        s_d.st       = DINIT_LOCK;
      end
      DINIT_LOCK: begin
        if (s_q.lock_cnt != 10'h0) begin
          s_d.lock_cnt = s_q.lock_cnt - 10'h1;
        end
        if (s_q.cnt == '0 && s_q.lock_cnt == 10'h0) begin
          s_d.done = 1'b1; // R13
          s_d.st   = DINIT_READY;
        end
      end
      DINIT_READY: begin
        if (mrs_req && banks_idle && s_q.mod_cnt == 4'h0 && s_q.cnt == '0) begin
          s_d.cmd      = `DINIT_CMD_MRS; // R17
          s_d.ba       = mrs_ba;
          s_d.addr     = mrs_val; // R15
          s_d.ack      = 1'b1;
          s_d.mod_cnt  = 4'(`DINIT_TMOD_CYC); // R19
          s_d.pden_cnt = 4'(`DINIT_TMRSPDEN_CYC); // R22
          s_d.cnt      = CNT_W'(`DINIT_TMRD_CYC - 1); // R18
        end
      end
      default: begin
        s_d.st = DINIT_RST_HOLD;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.st       <= DINIT_RST_HOLD;
      s_q.cmd      <= `DINIT_CMD_NOP;
      s_q.cnt      <= CNT_W'(RST_CYC);
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign mem_reset_n = s_q.reset_n;
  assign mem_cke     = s_q.cke; // R9
  assign mem_odt     = 1'b0; // R8 R21 R3
  assign mem_cs_n    = (s_q.cmd == `DINIT_CMD_NOP);
  assign mem_ras_n   = s_q.cmd[2];
  assign mem_cas_n   = s_q.cmd[1];
  assign mem_we_n    = s_q.cmd[0];
  assign mem_ba      = s_q.ba;
  assign mem_addr    = s_q.addr;
  assign mrs_ack     = s_q.ack;
  assign init_done   = s_q.done;
  assign mode_valid  = s_q.done && (s_q.mod_cnt == 4'h0); // R20
  assign pd_allowed  = s_q.done && (s_q.pden_cnt == 4'h0); // R22
  cke_c:  cover property (@(posedge core_clk) $rose(mem_cke));
  pd_c:   cover property (@(posedge core_clk) $rose(pd_allowed));

  // ==========================================================
  // Assertions
  mrs_gap_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R18
    (clk_en && !mem_cs_n && s_q.cmd == `DINIT_CMD_MRS) |=> 
      (mem_cs_n || s_q.cmd != `DINIT_CMD_MRS) [*3])
    else $error("MRS spacing too short");
  mod_nop_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R19
    (s_q.mod_cnt != 4'h0 && s_q.cmd != `DINIT_CMD_MRS) |-> mem_cs_n)
    else $error("Command inside tMOD");
  cke_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R9
    $rose(mem_cke) |=> mem_cke [*8])
    else $error("CKE dropped during init");
  odt_low_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R21
    (s_q.mod_cnt != 4'h0) |-> !mem_odt)
    else $error("ODT high during tMOD");
  first_mr2_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
    (s_q.st == DINIT_MRS_GAP && s_q.mr_idx == 2'h0 && $changed(s_q.st))
      |-> mem_ba == `DINIT_BA_MR2)
    else $error("First MRS not MR2");
  cke_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
    $rose(mem_reset_n) |-> !mem_cke && !$past(mem_cke, CKER_CYC))
    else $error("CKE high at reset release");
  pden_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R22
    pd_allowed |-> s_q.pden_cnt == 4'h0 && mem_cke)
    else $error("Power-down too early");
  dll_rst_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
    (s_q.st == DINIT_MRS_GAP && s_q.mr_idx == 2'h3 && $changed(s_q.st))
      |-> mem_addr[`DINIT_DLL_RST_BIT] && mem_ba == `DINIT_BA_MR0)
    else $error("MR0 lacks DLL reset");
  done_c: cover property (@(posedge core_clk) $rose(init_done));
  umrs_c: cover property (@(posedge core_clk) mrs_ack);
  zq_c:   cover property (@(posedge core_clk) s_q.st == DINIT_ZQ);
endmodule
`default_nettype wire

/* File: inc/dinit_consts.svh */
// Timing and encoding constants for the DDR3 init controller
`ifndef DINIT_CONSTS_SVH
`define DINIT_CONSTS_SVH
`define DINIT_CLK_NS        50
`define DINIT_RST_US        200
`define DINIT_CKE_RST_NS    10
`define DINIT_CKE_LOW_US    500
`define DINIT_CLK_VALID_NS  10
`define DINIT_CLK_VALID_MIN 5
`define DINIT_TXPR_CYC      5
`define DINIT_TMRD_CYC      4
`define DINIT_TMOD_CYC      12
`define DINIT_TDLLK_CYC     512
`define DINIT_TZQINIT_CYC   512
`define DINIT_TMRSPDEN_CYC  12
`define DINIT_DLL_RST_BIT   8
`define DINIT_BA_MR0        3'h0
`define DINIT_BA_MR1        3'h1
`define DINIT_BA_MR2        3'h2
`define DINIT_BA_MR3        3'h3
`define DINIT_CMD_NOP       3'h7
`define DINIT_CMD_MRS       3'h0
`define DINIT_CMD_ZQCL      3'h6
`define DINIT_ZQ_LONG_BIT   10
`endif

/* File: inc/dinit_pkg.sv */
// Types for the DDR3 init controller
package dinit_pkg;
  typedef enum logic [3:0] {
    DINIT_RST_HOLD, DINIT_CKE_WAIT, DINIT_CLK_WAIT, DINIT_XPR,
    DINIT_MRS, DINIT_MRS_GAP, DINIT_ZQ, DINIT_LOCK, DINIT_READY,
    DINIT_USER_MRS
  } dinit_state_e;
  typedef logic [15:0] dinit_addr_t;
endpackage

/* File: design/dinit_sync.sv */
// Two-flop synchroniser, one per bit
`timescale 1ns/1ns
`default_nettype none
module dinit_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[i] <= 1'b0;
          q[i]      <= 1'b0;
        end else begin
          meta_q[i] <= d[i];
          q[i]      <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: tb/dinit_dev_model.sv */
// Behavioural DDR3 device as seen from its command pins
`timescale 1ns/1ns
`default_nettype none
module dinit_dev_model
  import dinit_pkg::*;
(
  // Clock and reset pin
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Command pins
  input  wire logic        cke,
  input  wire logic        odt,
  input  wire logic        cs_n,
  input  wire logic [2:0]  cmd,
  input  wire logic [2:0]  ba,
  input  wire dinit_addr_t addr,
  // Observed state
  output dinit_addr_t      mr [4],
  output logic             term_on,
  output int               gap_err
);
  logic cke_seen;
  int   gap;
  // =====================================================
  // Termination and mode registers
  assign term_on = cke_seen & odt;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++)
        mr[i] <= 16'h0000;
      cke_seen <= 1'b0;
      gap      <= 100;
      gap_err  <= 0;
    end else begin
      gap <= gap + 1;
      if (cke)
        cke_seen <= 1'b1;
      if (!cs_n && cmd == 3'h0) begin
        // Whole value kept, DLL reset bit drops at once; no array access
        mr[ba[1:0]] <= (ba[1:0] == 2'h0) ? (addr & 16'hfeff) : addr;
        gap         <= 1;
        if (gap < 4 || !cke_seen)
          gap_err <= gap_err + 1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the DDR3 init controller
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import dinit_pkg::*;
;
  localparam int RST  = 20;
  localparam int CKEW = 30;
  typedef struct packed {
    logic [2:0]  cmd;
    logic [2:0]  ba;
    dinit_addr_t addr;
    dinit_addr_t mask;
  } dinit_row_s;
  logic        core_clk, arst_n, link_clk, link_run, pwr_stable, mrs_req, banks_idle, clk_en;
  logic        mrs_ack, init_done, mode_valid, pd_allowed, mem_reset_n, mem_cke, mem_odt;
  logic        mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, term_on, cke_up;
  logic [2:0]  mrs_ba, mem_ba;
  dinit_addr_t mrs_val, mem_addr;
  dinit_addr_t mr [4];
  int          gap_err, fails, check_count, n, t0, ckecyc;
  int          cyc = 0;
  dinit_row_s  rows [5];
  dinit_row_s  seen_q [$];
  int          stamp_q [$];
  // =====================================================
  // Clocks, design and device
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk & link_run;
  end
  dinit_ctrl #(.RST_CYC(RST), .CKE_CYC(CKEW)) u_dinit_ctrl (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .link_clk(link_clk),
    .pwr_stable(pwr_stable), .mr0_val(16'h0420), .mr1_val(16'h0044),
    .mr2_val(16'h0018), .mr3_val(16'h0004), .mrs_req(mrs_req), .mrs_ba(mrs_ba),
    .mrs_val(mrs_val), .banks_idle(banks_idle), .mrs_ack(mrs_ack),
    .init_done(init_done), .mode_valid(mode_valid), .pd_allowed(pd_allowed),
    .mem_reset_n(mem_reset_n), .mem_cke(mem_cke), .mem_odt(mem_odt),
    .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
    .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_addr(mem_addr));
  dinit_dev_model u_dinit_dev_model (
    .clk(core_clk), .reset_n(mem_reset_n), .cke(mem_cke), .odt(mem_odt),
    .cs_n(mem_cs_n), .cmd({mem_ras_n, mem_cas_n, mem_we_n}), .ba(mem_ba),
    .addr(mem_addr), .mr(mr), .term_on(term_on), .gap_err(gap_err));
  // =====================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_hi(input int sel, output int c);
    logic s;
    c = 0;
    do begin
      tick(1);
      c++;
      case (sel)
        0: s = mem_reset_n;
        1: s = mem_cke;
        2: s = init_done;
        3: s = mrs_ack;
        default: s = mode_valid;
      endcase
      if (c > 3000) begin
        fails++;
        test_done();
      end
    end while (s !== 1'b1);
  endtask
  // =====================================================
  // Command monitor
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cke_up && !init_done)
      check(mem_cke, 1'b1);
    if (arst_n && mem_cs_n === 1'b0) begin
      seen_q.push_back({mem_ras_n, mem_cas_n, mem_we_n, mem_ba, mem_addr, 16'h0000});
      stamp_q.push_back(cyc);
    end
  end
  // =====================================================
  // Main sequence
  initial begin
    arst_n = 0; link_run = 0; pwr_stable = 0; mrs_req = 0; cke_up = 0; clk_en = 1;
    mrs_ba = 3'h0; mrs_val = 16'h0000; banks_idle = 0; fails = 0; check_count = 0;
    rows[0] = {3'h0, 3'h2, 16'h0018, 16'hffff};
    rows[1] = {3'h0, 3'h3, 16'h0004, 16'hffff};
    rows[2] = {3'h0, 3'h1, 16'h0044, 16'hffff};
    rows[3] = {3'h0, 3'h0, 16'h0520, 16'hffff};
    rows[4] = {3'h6, 3'h0, 16'h0400, 16'h0400};
    tick(20);
    check({mem_reset_n, mem_cke, mem_cs_n}, 3'h1);
    arst_n = 1;
    tick(30);
    check(mem_reset_n, 1'b0);
    pwr_stable = 1;
    wait_hi(0, n);
    check(n >= RST, 1'b1);
    check(mem_cke, 1'b0);
    tick(CKEW - 2);
    link_run = 1;
    t0 = $time;
    wait_hi(1, n);
    ckecyc = cyc;
    cke_up = 1;
    check(n + CKEW - 2 >= CKEW, 1'b1);
    check($time - t0 >= 5 * 48, 1'b1);
    check({mem_odt, term_on}, 2'h0);
    wait_hi(2, n);
    check(seen_q.size(), 5);
    for (int i = 0; i < 5; i++) begin
      check(seen_q[i].cmd, rows[i].cmd);
      check(seen_q[i].addr & rows[i].mask, rows[i].addr);
      if (rows[i].mask == 16'hffff)
        check(seen_q[i].ba, rows[i].ba);
      if (i > 0)
        check(stamp_q[i] - stamp_q[i-1] >= ((i == 4) ? 12 : 4), 1'b1);
    end
    check(stamp_q[0] - ckecyc >= 5, 1'b1);
    check(cyc - stamp_q[4] >= 512, 1'b1);
    check({mr[0], mr[2]}, {16'h0420, 16'h0018});
    seen_q.delete();
    stamp_q.delete();
    mrs_ba = 3'h1; mrs_val = 16'h0046; mrs_req = 1;
    tick(20);
    check(seen_q.size(), 0);
    banks_idle = 1;
    wait_hi(3, n);
    check({mem_ba, mem_addr, mem_odt}, {3'h1, 16'h0046, 1'b0});
    check({mode_valid, pd_allowed}, 2'h0);
    mrs_val = 16'h0047;
    wait_hi(3, n);
    mrs_req = 0;
    check(n >= 4, 1'b1);
    wait_hi(4, n);
    check(n >= 11, 1'b1);
    tick(2);
    check(pd_allowed, 1'b1);
    check({mr[1], gap_err[7:0]}, {16'h0047, 8'h00});
    check(seen_q.size(), 2);
    clk_en = 0; mrs_val = 16'h0048; mrs_req = 1;
    tick(5);
    check({mrs_ack, mem_cs_n, pd_allowed}, 3'h3);
    clk_en = 1;
    wait_hi(3, n);
    mrs_req = 0;
    check({mem_ba, mem_addr}, {3'h1, 16'h0048});
    cke_up = 0;
    arst_n = 0;
    tick(3);
    check({mem_reset_n, mem_cke, init_done, mode_valid}, 4'h0);
    check(mr[1], 16'h0000);
    arst_n = 1;
    tick(2);
    check({mem_reset_n, mem_cke, mem_cs_n, init_done}, 4'h2);
    test_done();
  end
endmodule
`default_nettype wire
